// ---- iosp_consts.svh ----
`ifndef IOSP_CONSTS_SVH
`define IOSP_CONSTS_SVH

// Offset between an I/O-space number and its data-space address.
`define IOSP_DATA_OFS      8'h20
// Highest I/O number that the bit instructions may address.
`define IOSP_BIT_TOP       6'h1f
// Extended region, reachable by load and store only.
`define IOSP_EXT_LO        8'h60
`define IOSP_EXT_HI        8'hff
// Local registers, given as I/O-space numbers.
`define IOSP_SCRATCH0_IO   6'h1c
`define IOSP_SCRATCH1_IO   6'h1d
`define IOSP_SCRATCH2_IO   6'h1e
`define IOSP_FLAGS_IO      6'h1f
// Reset values.
`define IOSP_SCRATCH_RST   8'h00
`define IOSP_FLAGS_RST     8'h00
// Nonvolatile write duration.
`define IOSP_NVW_TIME_US   3400
`define IOSP_CLK_MHZ       10
`define IOSP_NVW_CYCLES    (`IOSP_NVW_TIME_US * `IOSP_CLK_MHZ)

`endif

// ---- iosp_pkg.sv ----
package iosp_pkg;

    typedef enum logic [3:0] {
        IOSP_OP_NONE    = 4'h0,
        IOSP_OP_IN      = 4'h1,
        IOSP_OP_OUT     = 4'h2,
        IOSP_OP_LOAD    = 4'h3,
        IOSP_OP_STORE   = 4'h4,
        IOSP_OP_SETBIT  = 4'h5,
        IOSP_OP_CLRBIT  = 4'h6,
        IOSP_OP_SKIPSET = 4'h7,
        IOSP_OP_SKIPCLR = 4'h8
    } iosp_op_t;

    typedef struct packed {
        logic [15:0] count;
        logic        busy;
        logic        done;
    } iosp_nvw_state_t;

    typedef struct packed {
        logic [2:0][7:0] scratch;
        logic [7:0]      flags;
        logic            p_valid;
        logic            p_local;
        logic [7:0]      p_ldata;
        iosp_op_t        p_op;
        logic [2:0]      p_bit;
        logic [7:0]      rdata;
        logic            rvalid;
        logic            skip;
        logic            err;
        logic [7:0]      per_addr;
        logic [7:0]      per_wdata;
        logic [7:0]      per_wmask;
        logic            per_we;
        logic            per_re;
    } iosp_state_t;

endpackage

// ---- iosp_nvw_keeper.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "iosp_consts.svh"

module iosp_nvw_keeper #(
    parameter int unsigned NVW_CYCLES = `IOSP_NVW_CYCLES
) (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    // Control
    input  wire logic start_i,
    // Status
    output logic      busy_o,
    output logic      done_o
);

    iosp_pkg::iosp_nvw_state_t s;
    iosp_pkg::iosp_nvw_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        if (s.busy) begin
            if (s.count == 16'h0001) begin
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
                next_s.count = 16'h0000;
            end else begin
                next_s.count = s.count - 16'h0001;
            end
        end else if (start_i && !rst_i) begin
            next_s.busy = 1'b1;
            next_s.count = NVW_CYCLES[15:0];
        end
    end

    // A write under way runs to its end through reset; only idle state is cleared.
    // The test is ordered so that an unknown busy bit at power-up still takes the reset.
    always_ff @(posedge ref_clk_i) begin
        if (s.busy || !rst_i) begin
            s <= next_s; // RQ11
        end else begin
            s <= '0;
        end
    end

    assign busy_o = s.busy;
    assign done_o = s.done;

endmodule
`default_nettype wire

// ---- iosp_io_space.sv ----
// How it works
// RQ1: Every peripheral register sits in one I/O space reachable by load and store.
// RQ2: Port in/out instructions use I/O numbers 0x00 to 0x3F from the opcode.
// RQ3: Data-space address of an I/O register is its I/O number plus 0x20.
// RQ4: I/O numbers 0x00 to 0x1F accept single-bit set and clear of one bit.
// RQ5: Those low 32 locations allow skip-if-bit-set and skip-if-bit-clear tests.
// RQ6: Extended region 0x60 to 0xFF is reached only by load and store.
// RQ7: Some status flags clear on writing one; writing zero leaves them.
// RQ8: Bit set and clear touch only their bit, sparing other clear-on-one flags.
// RQ9: Software writes zero to reserved bits and never writes reserved addresses.
// RQ10: Three scratch registers store any value with no side effect.
// RQ11: A nonvolatile write under way when reset comes is finished, not aborted.
`timescale 1ns/1ps
`default_nettype none
`include "iosp_consts.svh"

module iosp_io_space #(
    parameter int unsigned NVW_CYCLES = `IOSP_NVW_CYCLES
) (
    // Clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              rst_i,
    // CPU request
    input  wire logic              req_valid_i,
    input  wire iosp_pkg::iosp_op_t req_op_i,
    input  wire logic [5:0]        req_io_addr_i,
    input  wire logic [7:0]        req_data_addr_i,
    input  wire logic [2:0]        req_bit_i,
    input  wire logic [7:0]        req_wdata_i,
    // CPU answer
    output logic [7:0]             rdata_o,
    output logic                   rvalid_o,
    output logic                   skip_o,
    output logic                   err_o,
    // Peripheral side
    output logic [7:0]             per_addr_o,
    output logic [7:0]             per_wdata_o,
    output logic [7:0]             per_wmask_o,
    output logic                   per_we_o,
    output logic                   per_re_o,
    input  wire logic [7:0]        per_rdata_i,
    // Hardware flag events
    input  wire logic [7:0]        flag_set_i,
    output logic [7:0]             flags_o,
    // Scratch contents
    output logic [23:0]            scratch_o,
    // Nonvolatile write
    input  wire logic              nvw_start_i,
    output logic                   nvw_busy_o,
    output logic                   nvw_done_o
);

    iosp_pkg::iosp_state_t s;
    iosp_pkg::iosp_state_t next_s;

    // Decode results for the request now on the inputs.
    logic [7:0] daddr;
    logic [5:0] io_num;
    logic       bad;
    logic       is_wr;
    logic       is_rd;
    logic       is_bitop;
    logic [7:0] bmask;
    logic [7:0] wval;
    logic [7:0] wmask;
    logic [7:0] ldata;
    logic       hit_flags;
    logic [2:0] hit_scr;
    logic [7:0] rd_word;

    // Requests are decoded in one cycle; every answer leaves through the registered state.
    always_comb begin
        next_s = s;
        next_s.rvalid = 1'b0;
        next_s.skip = 1'b0;
        next_s.err = 1'b0;
        next_s.per_we = 1'b0;
        next_s.per_re = 1'b0;
        next_s.p_valid = 1'b0;
        bmask = 8'h01 << req_bit_i;
        is_bitop = 1'b0;
        is_wr = 1'b0;
        is_rd = 1'b0;
        wval = req_wdata_i;
        wmask = 8'hff;
        bad = 1'b0;
        daddr = req_data_addr_i;
        ldata = 8'h00;
        hit_scr = 3'b000;
        // Port instructions carry an I/O number; loads and stores carry a data address.
        unique case (req_op_i)
            iosp_pkg::IOSP_OP_IN: begin
                is_rd = 1'b1;
                daddr = {2'b00, req_io_addr_i} + `IOSP_DATA_OFS; // RQ2 RQ3
            end
            iosp_pkg::IOSP_OP_OUT: begin
                is_wr = 1'b1;
                daddr = {2'b00, req_io_addr_i} + `IOSP_DATA_OFS; // RQ2 RQ3
            end
            iosp_pkg::IOSP_OP_LOAD: begin
                is_rd = 1'b1;
                bad = (req_data_addr_i < `IOSP_DATA_OFS); // RQ1 RQ6
            end
            iosp_pkg::IOSP_OP_STORE: begin
                is_wr = 1'b1;
                bad = (req_data_addr_i < `IOSP_DATA_OFS); // RQ1 RQ6
            end
            iosp_pkg::IOSP_OP_SETBIT, iosp_pkg::IOSP_OP_CLRBIT: begin
                is_wr = 1'b1;
                is_bitop = 1'b1;
                wmask = bmask; // RQ8
                wval = (req_op_i == iosp_pkg::IOSP_OP_SETBIT) ? 8'hff : 8'h00;
                daddr = {2'b00, req_io_addr_i} + `IOSP_DATA_OFS;
            end
            iosp_pkg::IOSP_OP_SKIPSET, iosp_pkg::IOSP_OP_SKIPCLR: begin
                is_rd = 1'b1;
                is_bitop = 1'b1;
                daddr = {2'b00, req_io_addr_i} + `IOSP_DATA_OFS;
            end
            default: begin
                is_rd = 1'b0;
            end
        endcase
        // Bit instructions reach only the low 32 I/O numbers.
        if (is_bitop && (req_io_addr_i > `IOSP_BIT_TOP)) begin
            bad = 1'b1; // RQ4 RQ5
        end
        // I/O number of the data address; addresses below the window are refused above.
        io_num = 6'(daddr - `IOSP_DATA_OFS);
        hit_flags = (daddr < `IOSP_EXT_LO) && (io_num == `IOSP_FLAGS_IO);
        hit_scr[0] = (daddr < `IOSP_EXT_LO) && (io_num == `IOSP_SCRATCH0_IO);
        hit_scr[1] = (daddr < `IOSP_EXT_LO) && (io_num == `IOSP_SCRATCH1_IO);
        hit_scr[2] = (daddr < `IOSP_EXT_LO) && (io_num == `IOSP_SCRATCH2_IO);

        if (hit_flags) begin
            ldata = s.flags;
        end
        for (int i = 0; i < 3; i++) begin
            if (hit_scr[i]) begin
                ldata = s.scratch[i];
            end
        end

        if (req_valid_i && (is_rd || is_wr)) begin
            if (bad) begin
                next_s.err = 1'b1;
            end else if (hit_flags || (hit_scr != 3'b000)) begin
                // Writing one clears a flag; a bit instruction masks all other bits.
                if (is_wr && hit_flags) begin
                    next_s.flags = s.flags & ~(wval & wmask); // RQ7 RQ8
                end
                // Scratch writes merge under the mask, so bit instructions touch one bit.
                for (int i = 0; i < 3; i++) begin
                    if (is_wr && hit_scr[i]) begin
                        next_s.scratch[i] = (s.scratch[i] & ~wmask) | (wval & wmask); // RQ10
                    end
                end
                next_s.p_valid = is_rd;
                next_s.p_local = 1'b1;
                next_s.p_ldata = ldata;
            end else begin
                // Everything else in the data window goes out to the peripheral port.
                next_s.per_addr = daddr; // RQ1
                next_s.per_wdata = wval;
                next_s.per_wmask = wmask;
                next_s.per_we = is_wr;
                next_s.per_re = is_rd;
                next_s.p_valid = is_rd;
                next_s.p_local = 1'b0;
            end
            next_s.p_op = req_op_i;
            next_s.p_bit = req_bit_i;
        end

        // Hardware events are applied last so a set beats a same-cycle clear.
        next_s.flags = next_s.flags | flag_set_i;

        // A read answer leaves one edge after the fetch, two after the request.
        rd_word = s.p_local ? s.p_ldata : per_rdata_i;
        if (s.p_valid) begin
            if (s.p_op == iosp_pkg::IOSP_OP_SKIPSET) begin
                next_s.skip = rd_word[s.p_bit]; // RQ5
            end else if (s.p_op == iosp_pkg::IOSP_OP_SKIPCLR) begin
                next_s.skip = ~rd_word[s.p_bit]; // RQ5
            end else begin
                next_s.rdata = rd_word;
                next_s.rvalid = 1'b1;
            end
        end
    end

    // Reset clears all answers and registers; the keeper decides its own reset.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // A nonvolatile write keeps running through reset inside the keeper.
    iosp_nvw_keeper #(
        .NVW_CYCLES (NVW_CYCLES)
    ) u_nvw (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .start_i   (nvw_start_i),
        .busy_o    (nvw_busy_o),
        .done_o    (nvw_done_o)
    );

    // Every output except nvw_busy_o and nvw_done_o, which come from the keeper, is a field of the registered state.
    assign rdata_o     = s.rdata;
    assign rvalid_o    = s.rvalid;
    assign skip_o      = s.skip;
    assign err_o       = s.err;
    assign per_addr_o  = s.per_addr;
    assign per_wdata_o = s.per_wdata;
    assign per_wmask_o = s.per_wmask;
    assign per_we_o    = s.per_we;
    assign per_re_o    = s.per_re;
    assign flags_o     = s.flags;
    assign scratch_o   = s.scratch;

endmodule
`default_nettype wire

// ---- iosp_io_space_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module iosp_props (
    input wire logic               ref_clk_i,
    input wire logic               rst_i,
    input wire logic               req_valid_i,
    input wire iosp_pkg::iosp_op_t req_op_i,
    input wire logic [5:0]         req_io_addr_i,
    input wire logic [7:0]         req_data_addr_i,
    input wire logic [2:0]         req_bit_i,
    input wire logic [7:0]         req_wdata_i,
    input wire logic               rvalid_o,
    input wire logic               err_o,
    input wire logic [7:0]         per_addr_o,
    input wire logic [7:0]         per_wdata_o,
    input wire logic [7:0]         per_wmask_o,
    input wire logic               per_we_o,
    input wire logic               per_re_o,
    input wire logic [7:0]         flag_set_i,
    input wire logic [7:0]         flags_o,
    input wire logic [23:0]        scratch_o
);
    logic is_in, is_out, is_ld, is_st, is_set, is_bit;
    assign is_in = req_valid_i && req_op_i == iosp_pkg::IOSP_OP_IN;
    assign is_out = req_valid_i && req_op_i == iosp_pkg::IOSP_OP_OUT;
    assign is_ld = req_valid_i && req_op_i == iosp_pkg::IOSP_OP_LOAD;
    assign is_st = req_valid_i && req_op_i == iosp_pkg::IOSP_OP_STORE;
    assign is_set = req_valid_i && req_op_i == iosp_pkg::IOSP_OP_SETBIT;
    assign is_bit = is_set || (req_valid_i && req_op_i == iosp_pkg::IOSP_OP_CLRBIT);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    AST_IN_MAP: assert property (is_in && req_io_addr_i < 6'h1c |=> per_re_o
        && per_addr_o == $past({2'h0, req_io_addr_i}) + 8'h20 ##1 rvalid_o) else $error("in map");
    AST_LD_EXT: assert property (is_ld && req_data_addr_i >= 8'h60 |=> per_re_o
        && per_addr_o == $past(req_data_addr_i)) else $error("ext load");
    AST_ST_BYTE: assert property (is_st && req_data_addr_i >= 8'h40 |=> per_we_o
        && per_wmask_o == 8'hff && per_wdata_o == $past(req_wdata_i)) else $error("store");
    AST_LOW_ERR: assert property ((is_ld || is_st) && req_data_addr_i < 8'h20 |=>
        err_o && !per_we_o && !per_re_o) else $error("low data address");
    AST_BIT_ERR: assert property (is_bit && req_io_addr_i > 6'h1f |=> err_o
        && !per_we_o) else $error("bit op range");
    AST_BIT_ONE: assert property (is_set && req_io_addr_i < 6'h1c |=> per_we_o
        && per_wmask_o == 8'h01 << $past(req_bit_i) && per_wdata_o == 8'hff) else $error("bit");
    AST_FLAG_W1C: assert property (is_st && req_data_addr_i == 8'h3f && flag_set_i == 8'h00
        |=> flags_o == ($past(flags_o) & ~$past(req_wdata_i))) else $error("flag clear");
    AST_SCR_OUT: assert property (is_out && req_io_addr_i == 6'h1c |=>
        scratch_o[7:0] == $past(req_wdata_i)) else $error("scratch write");
endmodule
bind iosp_io_space iosp_props chk_u (.ref_clk_i, .rst_i, .req_valid_i, .req_op_i, .req_io_addr_i,
    .req_data_addr_i, .req_bit_i, .req_wdata_i, .rvalid_o, .err_o, .per_addr_o, .per_wdata_o,
    .per_wmask_o, .per_we_o, .per_re_o, .flag_set_i, .flags_o, .scratch_o);
`default_nettype wire

// ---- iosp_per_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module iosp_per_model (
    // Read request from the block
    input  wire logic [7:0] per_addr_i,
    input  wire logic       per_re_i,
    // Read answer
    output logic [7:0]      per_rdata_o
);
    // Outside a read strobe the bus shows the inverse so stale data cannot match.
    always_comb per_rdata_o = per_re_i ? per_addr_i ^ 8'h5a : ~(per_addr_i ^ 8'h5a);
endmodule
`default_nettype wire

// ---- test_io_space_register_access.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module test_io_space_register_access;
    localparam int NVW = 8;
    typedef struct {
        logic [3:0] op; logic [5:0] io; logic [7:0] da; logic [2:0] bt;
        logic [7:0] wd; int k; logic [7:0] ex;
    } iosp_row_t;
    logic ref_clk_i = 1'b0, rst_i = 1'b1, req_valid_i = 1'b0, nvw_start_i = 1'b0;
    iosp_pkg::iosp_op_t req_op_i = iosp_pkg::IOSP_OP_NONE;
    logic [5:0] req_io_addr_i = 6'h00;
    logic [7:0] req_data_addr_i = 8'h00, req_wdata_i = 8'h00, flag_set_i = 8'h00;
    logic [2:0] req_bit_i = 3'h0;
    logic [7:0] rdata_o, per_addr_o, per_wdata_o, per_wmask_o, per_rdata_i, flags_o, rd;
    logic rvalid_o, skip_o, err_o, per_we_o, per_re_o, nvw_busy_o, nvw_done_o, e1, rv, sk;
    logic [23:0] scratch_o;
    int n_fail = 0, compares = 0, n;
    iosp_row_t rows[18] = '{
        '{4'h2,6'h1c,8'h00,3'h0,8'ha5,0,8'h00}, '{4'h1,6'h1c,8'h00,3'h0,8'h00,1,8'ha5},
        '{4'h4,6'h00,8'h3d,3'h0,8'h3c,0,8'h00}, '{4'h3,6'h00,8'h3d,3'h0,8'h00,1,8'h3c},
        '{4'h5,6'h1e,8'h00,3'h7,8'h00,0,8'h00}, '{4'h3,6'h00,8'h3e,3'h0,8'h00,1,8'h80},
        '{4'h6,6'h1c,8'h00,3'h0,8'h00,0,8'h00}, '{4'h1,6'h1c,8'h00,3'h0,8'h00,1,8'ha4},
        '{4'h7,6'h1c,8'h00,3'h2,8'h00,2,8'h01}, '{4'h8,6'h1c,8'h00,3'h2,8'h00,2,8'h00},
        '{4'h8,6'h1c,8'h00,3'h0,8'h00,2,8'h01}, '{4'h5,6'h20,8'h00,3'h0,8'h00,3,8'h00},
        '{4'h3,6'h00,8'h1f,3'h0,8'h00,3,8'h00}, '{4'h1,6'h05,8'h00,3'h0,8'h00,1,8'h25 ^ 8'h5a},
        '{4'h3,6'h00,8'h60,3'h0,8'h00,1,8'h60 ^ 8'h5a}, '{4'h3,6'h00,8'hff,3'h0,8'h00,1,8'ha5},
        '{4'h5,6'h05,8'h00,3'h3,8'h00,0,8'h00}, '{4'h4,6'h00,8'h80,3'h0,8'h11,0,8'h00}};
    always #50 ref_clk_i = ~ref_clk_i;
    iosp_per_model per_u (.per_addr_i(per_addr_o), .per_re_i(per_re_o), .per_rdata_o(per_rdata_i));
    iosp_io_space #(.NVW_CYCLES(NVW)) dut_u (.ref_clk_i, .rst_i, .req_valid_i, .req_op_i,
        .req_io_addr_i, .req_data_addr_i, .req_bit_i, .req_wdata_i, .rdata_o, .rvalid_o, .skip_o,
        .err_o, .per_addr_o, .per_wdata_o, .per_wmask_o, .per_we_o, .per_re_o, .per_rdata_i,
        .flag_set_i, .flags_o, .scratch_o, .nvw_start_i, .nvw_busy_o, .nvw_done_o);
    task automatic req(input iosp_row_t r);
        @(negedge ref_clk_i);
        req_valid_i = 1'b1;
        req_op_i = iosp_pkg::iosp_op_t'(r.op);
        req_io_addr_i = r.io;
        req_data_addr_i = r.da;
        req_bit_i = r.bt;
        req_wdata_i = r.wd;
        @(negedge ref_clk_i);
        req_valid_i = 1'b0;
        e1 = err_o;
        @(negedge ref_clk_i);
        {rv, sk, rd} = {rvalid_o, skip_o, rdata_o};
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge ref_clk_i);
        rst_i = 1'b0;
        foreach (rows[i]) begin
            req(rows[i]);
            case (rows[i].k)
                0: `CHK("err", 1'b0, e1)
                1: `CHK("rdata", {1'b1, rows[i].ex}, {rv, rd})
                2: `CHK("skip", rows[i].ex[0], sk)
                default: `CHK("err", 1'b1, e1)
            endcase
        end
        $display("table test done");
        @(negedge ref_clk_i) flag_set_i = 8'h0f;
        @(negedge ref_clk_i) flag_set_i = 8'h00;
        req('{4'h4, 6'h00, 8'h3f, 3'h0, 8'h01, 0, 8'h00});
        `CHK("flags", 8'h0e, flags_o)
        req('{4'h4, 6'h00, 8'h3f, 3'h0, 8'h00, 0, 8'h00});
        `CHK("flags", 8'h0e, flags_o)
        req('{4'h5, 6'h1f, 8'h00, 3'h1, 8'h00, 0, 8'h00});
        `CHK("flags", 8'h0c, flags_o)
        @(negedge ref_clk_i);
        flag_set_i = 8'h04;
        req_valid_i = 1'b1;
        req_op_i = iosp_pkg::IOSP_OP_STORE;
        req_data_addr_i = 8'h3f;
        req_wdata_i = 8'h04;
        @(negedge ref_clk_i);
        flag_set_i = 8'h00;
        req_valid_i = 1'b0;
        `CHK("flags", 8'h0c, flags_o)
        $display("flag test done");
        @(negedge ref_clk_i) nvw_start_i = 1'b1;
        @(negedge ref_clk_i);
        nvw_start_i = 1'b0;
        rst_i = 1'b1;
        n = 1;
        while (nvw_done_o !== 1'b1 && n < 40) begin
            @(negedge ref_clk_i);
            `CHK("busy", n < NVW, nvw_busy_o)
            n++;
        end
        `CHK("write length", NVW + 1, n)
        if (n >= 40) results();
        `CHK("scratch", 24'h000000, scratch_o)
        `CHK("flags", 8'h00, flags_o)
        rst_i = 1'b0;
        req('{4'h1, 6'h1c, 8'h00, 3'h0, 8'h00, 1, 8'h00});
        `CHK("rdata", 9'h100, {rv, rd})
        `CHK("busy", 1'b0, nvw_busy_o)
        $display("reset test done");
        results();
    end
endmodule
`default_nettype wire
